// >>> logic/home_seek_pkg.sv
// Constants, encodings and reset values shared by the home-seeking sequencer
package home_seek_pkg;

   localparam int SPEED_W = 20;
   localparam int POS_W = 32;
   localparam int OFFSET_W = 24;

   // Homing method encodings
   localparam logic [1:0] MODE_TWO_SENSOR = 2'h0;
   localparam logic [1:0] MODE_THREE_SENSOR = 2'h1;
   localparam logic [1:0] MODE_PUSH = 2'h2;

   localparam logic DIR_NEGATIVE = 1'h0;
   localparam logic DIR_POSITIVE = 1'h1;

   // Setting reset values
   localparam logic [1:0] MODE_RESET = MODE_THREE_SENSOR;
   localparam logic [SPEED_W-1:0] RUN_SPEED_RESET = 20'h003E8;
   localparam logic [SPEED_W-1:0] ACCEL_RESET = 20'h003E8;
   localparam logic [SPEED_W-1:0] START_SPEED_RESET = 20'h001F4;
   localparam logic [OFFSET_W-1:0] OFFSET_RESET = 24'h000000;
   localparam logic START_DIR_RESET = DIR_POSITIVE;
   localparam logic SENSOR_A_EN_RESET = 1'h0;
   localparam logic TIMING_EN_RESET = 1'h0;
   localparam logic [POS_W-1:0] PRESET_POS_RESET = 32'h00000000;
   localparam logic [POS_W-1:0] POSITION_HOME = 32'h00000000;

   // Accepted range of speeds and of the ramp setting
   localparam logic [SPEED_W-1:0] SETTING_MIN = 20'h00001;
   localparam logic [SPEED_W-1:0] SETTING_MAX = 20'hF4240;

   // Escape travel and final approach cap
   localparam logic [OFFSET_W-1:0] ESCAPE_STEPS = 24'h0000C8;
   localparam logic [SPEED_W-1:0] FINAL_SPEED_CAP = 20'h001F4;

   // Positions of pin inputs in the synchroniser vector
   localparam int PIN_HOME_REQ = 0;
   localparam int PIN_PRESET_REQ = 1;
   localparam int PIN_HOME_SENSOR = 2;
   localparam int PIN_SENSOR_A = 3;
   localparam int PIN_POS_LIMIT = 4;
   localparam int PIN_NEG_LIMIT = 5;
   localparam int PIN_COUNT = 6;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SEEK = 3'h1,
      ST_ESCAPE = 3'h3,
      ST_TRAVEL = 3'h2,
      ST_OFFSET = 3'h6,
      ST_FINISH = 3'h7,
      ST_QUALIFY = 3'h5
   } seek_state_t;

endpackage : home_seek_pkg

// >>> logic/pin_synchronizer.sv
// Three-stage pin synchroniser that passes a change once stages two and three agree
module pin_synchronizer #(
   parameter int WIDTH = 6
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
      logic [WIDTH-1:0] stage3;
      logic [WIDTH-1:0] stable;
   } sync_t;

   sync_t q;
   sync_t d;
   logic [WIDTH-1:0] agree;

   // Stage one feeds stage two only
   for (genvar i = 0; i < WIDTH; i++) begin : g_agree
      assign agree[i] = (q.stage2[i] == q.stage3[i]);
   end

   always_comb begin
      d = q;
      d.stage1 = async_in;
      d.stage2 = q.stage1;
      d.stage3 = q.stage2;
      d.stable = (q.stable & ~agree) | (q.stage3 & agree);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.stable;

endmodule : pin_synchronizer

// >>> logic/home_seeking_sequencer.sv
// Return-to-home sequencer: homing methods, offset move, preset and status outputs
module home_seeking_sequencer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic home_request,
   input wire logic preset_request,
   input wire logic home_sensor,
   input wire logic sensor_a,
   input wire logic positive_limit_sensor,
   input wire logic negative_limit_sensor,
   input wire logic excitation_timing_signal,
   input wire logic load_pressed,
   input wire logic step_done,
   input wire logic cfg_write,
   input wire logic [1:0] cfg_home_mode,
   input wire logic [home_seek_pkg::SPEED_W-1:0] cfg_seek_run_speed,
   input wire logic [home_seek_pkg::SPEED_W-1:0] cfg_seek_accel,
   input wire logic [home_seek_pkg::SPEED_W-1:0] cfg_seek_start_speed,
   input wire logic [home_seek_pkg::OFFSET_W-1:0] cfg_home_offset,
   input wire logic cfg_start_dir,
   input wire logic cfg_sensor_a_enable,
   input wire logic cfg_timing_enable,
   input wire logic [home_seek_pkg::POS_W-1:0] cfg_preset_position,
   output logic ready,
   output logic move,
   output logic motion_end,
   output logic home_complete,
   output logic cfg_reject,
   output logic drive_run,
   output logic drive_dir,
   output logic [home_seek_pkg::SPEED_W-1:0] drive_speed,
   output logic [home_seek_pkg::SPEED_W-1:0] drive_accel,
   output logic [home_seek_pkg::POS_W-1:0] command_position
);

   typedef struct packed {
      home_seek_pkg::seek_state_t state;
      logic [1:0] mode;
      logic [home_seek_pkg::SPEED_W-1:0] run_speed;
      logic [home_seek_pkg::SPEED_W-1:0] accel;
      logic [home_seek_pkg::SPEED_W-1:0] start_speed;
      logic [home_seek_pkg::OFFSET_W-1:0] offset;
      logic start_dir;
      logic sensor_a_en;
      logic timing_en;
      logic [home_seek_pkg::POS_W-1:0] preset_pos;
      logic home_req_prev;
      logic preset_req_prev;
      logic [home_seek_pkg::OFFSET_W-1:0] steps_left;
      logic offset_done;
      logic ready;
      logic move;
      logic motion_end;
      logic home_complete;
      logic cfg_reject;
      logic run;
      logic dir;
      logic [home_seek_pkg::SPEED_W-1:0] speed;
      logic [home_seek_pkg::POS_W-1:0] position;
   } seq_t;

   localparam seq_t SEQ_RESET = '{
      state: home_seek_pkg::ST_IDLE,
      mode: home_seek_pkg::MODE_RESET,
      run_speed: home_seek_pkg::RUN_SPEED_RESET,
      accel: home_seek_pkg::ACCEL_RESET,
      start_speed: home_seek_pkg::START_SPEED_RESET,
      offset: home_seek_pkg::OFFSET_RESET,
      start_dir: home_seek_pkg::START_DIR_RESET,
      sensor_a_en: home_seek_pkg::SENSOR_A_EN_RESET,
      timing_en: home_seek_pkg::TIMING_EN_RESET,
      preset_pos: home_seek_pkg::PRESET_POS_RESET,
      home_req_prev: 1'h0,
      preset_req_prev: 1'h0,
      steps_left: '0,
      offset_done: 1'h0,
      ready: 1'h1,
      move: 1'h0,
      motion_end: 1'h1,
      home_complete: 1'h0,
      cfg_reject: 1'h0,
      run: 1'h0,
      dir: home_seek_pkg::START_DIR_RESET,
      speed: '0,
      position: home_seek_pkg::POSITION_HOME
   };

   seq_t q;
   seq_t d;

   logic [home_seek_pkg::PIN_COUNT-1:0] pins_raw;
   logic [home_seek_pkg::PIN_COUNT-1:0] pins_s;
   logic home_req_s;
   logic preset_req_s;
   logic home_s;
   logic sensor_a_s;
   logic pos_lim_s;
   logic neg_lim_s;
   logic home_edge;
   logic preset_edge;
   logic limit_ahead;
   logic limit_behind;
   logic qualify_on;
   logic qualified;
   logic counted_step;
   logic [home_seek_pkg::SPEED_W-1:0] final_speed;
   logic [home_seek_pkg::OFFSET_W-1:0] offset_mag;

   assign pins_raw[home_seek_pkg::PIN_HOME_REQ] = home_request;
   assign pins_raw[home_seek_pkg::PIN_PRESET_REQ] = preset_request;
   assign pins_raw[home_seek_pkg::PIN_HOME_SENSOR] = home_sensor;
   assign pins_raw[home_seek_pkg::PIN_SENSOR_A] = sensor_a;
   assign pins_raw[home_seek_pkg::PIN_POS_LIMIT] = positive_limit_sensor;
   assign pins_raw[home_seek_pkg::PIN_NEG_LIMIT] = negative_limit_sensor;

   pin_synchronizer #(
      .WIDTH(home_seek_pkg::PIN_COUNT)
   ) u_pin_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   assign home_req_s = pins_s[home_seek_pkg::PIN_HOME_REQ];
   assign preset_req_s = pins_s[home_seek_pkg::PIN_PRESET_REQ];
   assign home_s = pins_s[home_seek_pkg::PIN_HOME_SENSOR];
   assign sensor_a_s = pins_s[home_seek_pkg::PIN_SENSOR_A];
   assign pos_lim_s = pins_s[home_seek_pkg::PIN_POS_LIMIT];
   assign neg_lim_s = pins_s[home_seek_pkg::PIN_NEG_LIMIT];

   // edge-started request
   // Edge, not level, so a request still held after completion cannot restart
   assign home_edge = home_req_s & ~q.home_req_prev;
   assign preset_edge = preset_req_s & ~q.preset_req_prev;

   assign limit_ahead = q.dir ? pos_lim_s : neg_lim_s;
   assign limit_behind = q.dir ? neg_lim_s : pos_lim_s;

   assign qualify_on = q.sensor_a_en | q.timing_en;
   assign qualified = (~q.sensor_a_en | sensor_a_s) & (~q.timing_en | excitation_timing_signal);

   assign final_speed = (q.start_speed < home_seek_pkg::FINAL_SPEED_CAP) ?
                        q.start_speed : home_seek_pkg::FINAL_SPEED_CAP;

   // signed offset magnitude
   // Most negative offset still fits, as an unsigned 24-bit magnitude
   assign offset_mag = q.offset[home_seek_pkg::OFFSET_W-1] ? (~q.offset + 24'h000001) : q.offset;

   assign counted_step = step_done & q.run;

   always_comb begin
      d = q;
      d.home_req_prev = home_req_s;
      d.preset_req_prev = preset_req_s;
      d.cfg_reject = 1'h0;

      if (counted_step) begin
         d.position = q.dir ? (q.position + 32'h00000001) : (q.position - 32'h00000001);
         if (q.steps_left != '0) begin
            d.steps_left = q.steps_left - 24'h000001;
         end
         // Drop the run request on the last counted step, not a cycle late
         if ((q.state == home_seek_pkg::ST_TRAVEL || q.state == home_seek_pkg::ST_OFFSET) &&
             q.steps_left == 24'h000001) begin
            d.run = 1'h0;
         end
      end

      unique case (q.state)
         home_seek_pkg::ST_IDLE: begin
            if (cfg_write) begin
               if (cfg_home_mode <= home_seek_pkg::MODE_PUSH) begin
                  d.mode = cfg_home_mode;
               end else begin
                  d.cfg_reject = 1'h1;
               end
               if (cfg_seek_run_speed >= home_seek_pkg::SETTING_MIN &&
                   cfg_seek_run_speed <= home_seek_pkg::SETTING_MAX) begin
                  d.run_speed = cfg_seek_run_speed;
               end else begin
                  d.cfg_reject = 1'h1;
               end
               if (cfg_seek_accel >= home_seek_pkg::SETTING_MIN &&
                   cfg_seek_accel <= home_seek_pkg::SETTING_MAX) begin
                  d.accel = cfg_seek_accel;
               end else begin
                  d.cfg_reject = 1'h1;
               end
               if (cfg_seek_start_speed >= home_seek_pkg::SETTING_MIN &&
                   cfg_seek_start_speed <= home_seek_pkg::SETTING_MAX) begin
                  d.start_speed = cfg_seek_start_speed;
               end else begin
                  d.cfg_reject = 1'h1;
               end
               d.offset = cfg_home_offset;
               d.start_dir = cfg_start_dir;
               d.sensor_a_en = cfg_sensor_a_enable;
               d.timing_en = cfg_timing_enable;
               d.preset_pos = cfg_preset_position;
            end else if (home_edge) begin
               d.state = home_seek_pkg::ST_SEEK;
               d.ready = 1'h0;
               d.move = 1'h1;
               d.motion_end = 1'h0;
               d.home_complete = 1'h0;
               d.offset_done = 1'h0;
               d.run = 1'h1;
               d.dir = q.start_dir;
               d.speed = (q.mode == home_seek_pkg::MODE_THREE_SENSOR) ? q.run_speed : q.start_speed;
            end else if (preset_edge) begin
               d.position = q.preset_pos;
            end
         end

         home_seek_pkg::ST_SEEK: begin
            unique case (q.mode)
               home_seek_pkg::MODE_THREE_SENSOR: begin
                  if (home_s) begin
                     if (qualify_on) begin
                        d.state = home_seek_pkg::ST_QUALIFY;
                        d.speed = final_speed;
                     end else begin
                        d.run = 1'h0;
                        d.state = home_seek_pkg::ST_FINISH;
                        d.steps_left = '0;
                     end
                  end else if (limit_ahead) begin
                     // Limit before home: turn round and keep searching
                     d.dir = ~q.dir;
                  end
               end
               home_seek_pkg::MODE_TWO_SENSOR: begin
                  if (limit_ahead) begin
                     d.dir = ~q.dir;
                     d.state = home_seek_pkg::ST_ESCAPE;
                  end
               end
               home_seek_pkg::MODE_PUSH: begin
                  if (load_pressed) begin
                     d.dir = ~q.dir;
                     d.steps_left = home_seek_pkg::ESCAPE_STEPS;
                     d.state = home_seek_pkg::ST_TRAVEL;
                  end
               end
               default: begin
                  d.run = 1'h0;
                  d.state = home_seek_pkg::ST_FINISH;
               end
            endcase
         end

         home_seek_pkg::ST_ESCAPE: begin
            if (!limit_behind) begin
               d.steps_left = home_seek_pkg::ESCAPE_STEPS;
               d.state = home_seek_pkg::ST_TRAVEL;
            end
         end

         home_seek_pkg::ST_QUALIFY: begin
            // finish on signal with home on
            if (home_s && qualified) begin
               d.run = 1'h0;
               d.steps_left = '0;
               d.state = home_seek_pkg::ST_FINISH;
            end
         end

         home_seek_pkg::ST_TRAVEL,
         home_seek_pkg::ST_OFFSET: begin
            if (q.steps_left == '0) begin
               d.run = 1'h0;
               d.state = home_seek_pkg::ST_FINISH;
            end
         end

         home_seek_pkg::ST_FINISH: begin
            // One offset move per homing, whatever speed the search ended at
            if (q.offset != '0 && !q.offset_done) begin
               d.offset_done = 1'h1;
               d.state = home_seek_pkg::ST_OFFSET;
               d.dir = ~q.offset[home_seek_pkg::OFFSET_W-1];
               d.steps_left = offset_mag;
               d.speed = q.run_speed;
               d.run = 1'h1;
            end else begin
               d.position = home_seek_pkg::POSITION_HOME;
               d.home_complete = 1'h1;
               d.move = 1'h0;
               d.ready = 1'h1;
               d.motion_end = 1'h1;
               d.run = 1'h0;
               d.state = home_seek_pkg::ST_IDLE;
            end
         end

         default: begin
            d.state = home_seek_pkg::ST_IDLE;
            d.run = 1'h0;
            d.move = 1'h0;
            d.ready = 1'h1;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= SEQ_RESET;
      end else begin
         q <= d;
      end
   end

   assign ready = q.ready;
   assign move = q.move;
   assign motion_end = q.motion_end;
   assign home_complete = q.home_complete;
   assign cfg_reject = q.cfg_reject;
   assign drive_run = q.run;
   assign drive_dir = q.dir;
   assign drive_speed = q.speed;
   assign drive_accel = q.accel;
   assign command_position = q.position;

endmodule : home_seeking_sequencer

// >>> dv/seek_machine_model.sv
// Pulse generator and machine model: steps, sensors, stopper and timing signal
module seek_machine_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic drive_run,
   input wire logic drive_dir,
   output logic step_done,
   output logic home_sensor,
   output logic sensor_a,
   output logic positive_limit_sensor,
   output logic negative_limit_sensor,
   output logic load_pressed,
   output logic excitation_timing_signal,
   output int pos
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] tick_q = 4'h0;
   initial begin
      pos = 0;
      step_done = 1'b0;
   end
   // Ten cycles a step, so a synchronised sensor settles before the next step
   always @(posedge sys_clk) begin
      step_done <= drive_run && tick_q == 4'h9;
      tick_q <= (drive_run && tick_q != 4'h9) ? tick_q + 4'h1 : 4'h0;
      if (rst) begin
         pos <= 0;
      end else if (drive_run && tick_q == 4'h9) begin
         pos <= drive_dir ? pos + 1 : pos - 1;
      end
   end
   assign home_sensor = pos >= 100 && pos <= 140;
   assign sensor_a = pos == 120;
   assign positive_limit_sensor = pos >= 400;
   assign negative_limit_sensor = pos <= -1000;
   assign load_pressed = pos <= -300;
   assign excitation_timing_signal = pos % 16 == 0;
endmodule : seek_machine_model

// >>> dv/home_seek_asserts.sv
// Port-level assertions for the home-seeking sequencer
module home_seek_asserts (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic preset_request,
   input wire logic home_sensor,
   input wire logic positive_limit_sensor,
   input wire logic negative_limit_sensor,
   input wire logic step_done,
   input wire logic cfg_write,
   input wire logic [1:0] cfg_home_mode,
   input wire logic [home_seek_pkg::SPEED_W-1:0] cfg_seek_run_speed,
   input wire logic [home_seek_pkg::SPEED_W-1:0] cfg_seek_accel,
   input wire logic [home_seek_pkg::SPEED_W-1:0] cfg_seek_start_speed,
   input wire logic cfg_start_dir,
   input wire logic cfg_sensor_a_enable,
   input wire logic cfg_timing_enable,
   input wire logic [home_seek_pkg::POS_W-1:0] cfg_preset_position,
   input wire logic ready,
   input wire logic move,
   input wire logic motion_end,
   input wire logic home_complete,
   input wire logic cfg_reject,
   input wire logic drive_run,
   input wire logic drive_dir,
   input wire logic [home_seek_pkg::SPEED_W-1:0] drive_speed,
   input wire logic [home_seek_pkg::POS_W-1:0] command_position
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] steps_q;
   logic dir_q;
   logic lim_q;
   logic run_q;
   logic fell_q;
   function automatic logic out(input logic [19:0] v);
      return v == 20'h00000 || v > 20'hF4240;
   endfunction : out
   wire lim = positive_limit_sensor | negative_limit_sensor;
   wire three = cfg_home_mode == home_seek_pkg::MODE_THREE_SENSOR;
   wire qual = cfg_sensor_a_enable | cfg_timing_enable;
   wire [19:0] fin = (cfg_seek_start_speed < 20'h001F4) ? cfg_seek_start_speed : 20'h001F4;
   wire bad = cfg_home_mode == 2'h3 || out(cfg_seek_run_speed) || out(cfg_seek_accel)
      || out(cfg_seek_start_speed);
   // Steps since the last reversal or limit release; only the first stop counts
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         steps_q <= 32'h0;
         dir_q <= 1'b1;
         lim_q <= 1'b0;
         run_q <= 1'b0;
         fell_q <= 1'b0;
      end else begin
         dir_q <= drive_dir;
         lim_q <= lim;
         run_q <= drive_run;
         fell_q <= ready ? 1'b0 : (fell_q | (run_q & !drive_run));
         if (drive_dir != dir_q || (lim_q && !lim)) begin
            steps_q <= 32'h0;
         end else if (step_done && drive_run) begin
            steps_q <= steps_q + 32'h1;
         end
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   a_idle_flags: assert property (ready |-> !move && motion_end)
      else $error("ready while moving");
   a_start_flags: assert property ($fell(ready) |-> move && drive_run && !motion_end && !home_complete)
      else $error("bad flags at homing start");
   a_start_dir: assert property ($fell(ready) |-> drive_dir == cfg_start_dir)
      else $error("wrong start direction");
   a_start_speed: assert property ($fell(ready) |->
      drive_speed == (three ? cfg_seek_run_speed : cfg_seek_start_speed))
      else $error("wrong seek speed");
   a_done_state: assert property ($rose(home_complete) |->
      ready && !move && motion_end && !drive_run && command_position == 32'h0)
      else $error("bad state at completion");
   a_escape_count: assert property (run_q && !drive_run && !fell_q && !three |->
      steps_q == 32'h000000C8)
      else $error("escape travel not 200 steps");
   a_three_halt: assert property ($rose(home_sensor) && move && three && !qual |->
      ##[1:10] !drive_run)
      else $error("no halt on home sensor");
   a_final_speed: assert property ($rose(home_sensor) && move && three && qual |->
      ##[1:10] drive_speed == fin)
      else $error("wrong final approach speed");
   a_preset_load: assert property ($rose(preset_request) && ready && !cfg_write |->
      ##[2:12] command_position == cfg_preset_position)
      else $error("preset not loaded");
   a_reject_flag: assert property (cfg_write && ready |=> cfg_reject == $past(bad))
      else $error("wrong setting reject");
endmodule : home_seek_asserts
bind home_seeking_sequencer home_seek_asserts u_chk (
   .sys_clk, .rst, .preset_request, .home_sensor, .positive_limit_sensor,
   .negative_limit_sensor, .step_done, .cfg_write, .cfg_home_mode, .cfg_seek_run_speed,
   .cfg_seek_accel, .cfg_seek_start_speed, .cfg_start_dir, .cfg_sensor_a_enable,
   .cfg_timing_enable, .cfg_preset_position, .ready, .move, .motion_end, .home_complete,
   .cfg_reject, .drive_run, .drive_dir, .drive_speed, .command_position
);

// >>> dv/home_seeking_sequencer_bench.sv
// Self-checking bench: homing methods, offset, qualification, preset, settings
module home_seeking_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic home_request = 1'b0;
   logic preset_request = 1'b0;
   logic cfg_write = 1'b0;
   logic [1:0] cfg_home_mode = 2'h1;
   logic [19:0] cfg_seek_run_speed = 20'h003E8;
   logic [19:0] cfg_seek_accel = 20'h003E8;
   logic [19:0] cfg_seek_start_speed = 20'h001F4;
   logic [23:0] cfg_home_offset = 24'h000000;
   logic cfg_start_dir = 1'b1;
   logic cfg_sensor_a_enable = 1'b0;
   logic cfg_timing_enable = 1'b0;
   logic [31:0] cfg_preset_position = 32'h00000000;
   logic home_sensor, sensor_a, positive_limit_sensor, negative_limit_sensor;
   logic excitation_timing_signal, load_pressed, step_done;
   logic ready, move, motion_end, home_complete, cfg_reject, drive_run, drive_dir;
   logic [19:0] drive_speed, drive_accel;
   logic [31:0] command_position, r;
   int mech_pos, off, i;
   int fails = 0;
   int comparisons = 0;
   int seed = 99538;
   always #20 sys_clk = ~sys_clk;
   home_seeking_sequencer dut (.sys_clk, .rst, .home_request, .preset_request, .home_sensor,
      .sensor_a, .positive_limit_sensor, .negative_limit_sensor, .excitation_timing_signal,
      .load_pressed, .step_done, .cfg_write, .cfg_home_mode, .cfg_seek_run_speed,
      .cfg_seek_accel, .cfg_seek_start_speed, .cfg_home_offset, .cfg_start_dir,
      .cfg_sensor_a_enable, .cfg_timing_enable, .cfg_preset_position, .ready, .move, .motion_end,
      .home_complete, .cfg_reject, .drive_run, .drive_dir, .drive_speed, .drive_accel,
      .command_position);
   seek_machine_model machine (.sys_clk, .rst, .drive_run, .drive_dir, .step_done,
      .home_sensor, .sensor_a, .positive_limit_sensor, .negative_limit_sensor, .load_pressed,
      .excitation_timing_signal, .pos(mech_pos));
   function automatic logic bad(input logic [1:0] m, input logic [19:0] a, b, c);
      return m == 2'h3 || a == 20'h0 || b == 20'h0 || c == 20'h0 || a > 20'hF4240
         || b > 20'hF4240 || c > 20'hF4240;
   endfunction : bad
   function automatic logic [19:0] pick(input logic [31:0] v);
      case (v % 5)
         0: return 20'h00000;
         1: return 20'h00001;
         2: return 20'hF4240;
         3: return 20'hF4241;
         default: return v[19:0];
      endcase
   endfunction : pick
   task automatic conclude;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         fails++;
         $display("[ERR] %0t waited %h limit %h", $time, n, lim);
         conclude();
      end
   endtask : guard
   // Inputs always change 2 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : tick
   task automatic reset_dut;
      rst = 1'b1;
      tick(12);
      rst = 1'b0;
      tick(4);
   endtask : reset_dut
   task automatic cfg(input logic [1:0] m, input logic [19:0] rs, ac, ss,
         input logic [23:0] o, input logic d, sl, tm, input logic [31:0] p);
      cfg_home_mode = m;
      cfg_seek_run_speed = rs;
      cfg_seek_accel = ac;
      cfg_seek_start_speed = ss;
      cfg_home_offset = o;
      cfg_start_dir = d;
      cfg_sensor_a_enable = sl;
      cfg_timing_enable = tm;
      cfg_preset_position = p;
      cfg_write = 1'b1;
      tick(1);
      cfg_write = 1'b0;
      chk(cfg_reject, bad(m, rs, ac, ss));
      tick(1);
   endtask : cfg
   task automatic home(input int exp_pos, input logic [19:0] exp_spd);
      int n;
      n = 0;
      chk(ready, 1'b1);
      home_request = 1'b1;
      while (ready === 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      guard(n, 40);
      chk({ready, move, motion_end, home_complete}, 4'h4);
      chk(drive_speed, exp_spd);
      chk(drive_dir, cfg_start_dir);
      home_request = 1'b0;
      n = 0;
      while (home_complete !== 1'b1 && n < 20000) begin
         tick(1);
         n++;
      end
      guard(n, 20000);
      chk({ready, move, motion_end, home_complete}, 4'hB);
      chk(command_position, 32'h0);
      chk(mech_pos, exp_pos);
      tick(2);
   endtask : home
   initial begin
      reset_dut();
      chk({ready, move, motion_end, home_complete, cfg_reject, drive_run, drive_dir}, 7'h51);
      chk(drive_accel, 20'h003E8);
      home(100, 20'h003E8);
      for (int k = 0; k < 3; k++) begin
         reset_dut();
         off = $random(seed) % 21;
         r = $random(seed);
         cfg(2'h1, 20'h00400 + 20'(k), 20'h003E8, 20'h001F4, off[23:0], 1'b1, 1'b0, 1'b0, r);
         home(100 + off, 20'h00400 + 20'(k));
         preset_request = 1'b1;
         i = 0;
         while (command_position !== r && i < 12) begin
            tick(1);
            i++;
         end
         guard(i, 12);
         chk(command_position, r);
         chk(home_complete, 1'b1);
         preset_request = 1'b0;
         tick(6);
      end
      reset_dut();
      cfg(2'h0, 20'h003E8, 20'h003E8, 20'h00123, 24'h0, 1'b1, 1'b0, 1'b0, 32'h0);
      home(199, 20'h00123);
      reset_dut();
      cfg(2'h2, 20'h00800, 20'h003E8, 20'h00155, 24'hFFFFFB, 1'b0, 1'b0, 1'b0, 32'h0);
      home(-105, 20'h00155);
      for (int k = 0; k < 2; k++) begin
         reset_dut();
         cfg(2'h1, 20'h003E8, 20'h003E8, k ? 20'h0012C : 20'h00320, 24'h0, 1'b1, k == 0, k == 1,
            32'h0);
         home(k ? 112 : 120, 20'h003E8);
      end
      reset_dut();
      cfg(2'h1, 20'h00001, 20'hF4240, 20'h00001, 24'h800000, 1'b1, 1'b0, 1'b0, 32'h0);
      chk(drive_accel, 20'hF4240);
      repeat (16) begin
         r = $random(seed);
         cfg(r[1:0], pick($random(seed)), pick($random(seed)), pick($random(seed)), r[27:4],
            r[28], r[29], r[30], r);
      end
      conclude();
   end
endmodule : home_seeking_sequencer_bench
